// ===== design/twm_pkg.sv
`default_nettype none

package twm_pkg;

    // ----------------------------------------------------------------
    // Register map, byte addresses on the APB
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_DATA   = 8'h08;

    // ----------------------------------------------------------------
    // Control register bit positions
    // ----------------------------------------------------------------
    localparam int CTL_FLAG  = 7;
    localparam int CTL_START = 5;
    localparam int CTL_STOP  = 4;
    localparam int CTL_EN    = 2;
    localparam int CTL_IE    = 0;

    // ----------------------------------------------------------------
    // Status codes, prescaler bits always zero
    // ----------------------------------------------------------------
    localparam logic [7:0] ST_START     = 8'h08;
    localparam logic [7:0] ST_ADDR_ACK  = 8'h18;
    localparam logic [7:0] ST_ADDR_NACK = 8'h20;
    localparam logic [7:0] ST_DATA_ACK  = 8'h28;
    localparam logic [7:0] ST_DATA_NACK = 8'h30;
    localparam logic [7:0] ST_NONE      = 8'hF8;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_NS      = 4;
    localparam int SCL_HALF_NS = 1250;
    localparam int HALF_CYC    = SCL_HALF_NS / CLK_NS;

    typedef enum logic [1:0] {
        CMD_START,
        CMD_BYTE,
        CMD_STOP
    } twm_cmd_t;

endpackage

`default_nettype wire

// ===== design/twm_bit_if.sv
`timescale 1ns/1ps
`default_nettype none

interface twm_bit_if;
    logic               cmd_valid;
    twm_pkg::twm_cmd_t  cmd;
    logic [7:0]         tx_byte;
    logic               ready;
    logic               done;
    logic               nack;
    logic               scl_low;
    logic               sda_low;
    logic               scl_in;
    logic               sda_in;

    modport ctl (
        output cmd_valid, cmd, tx_byte, scl_in, sda_in,
        input  ready, done, nack, scl_low, sda_low
    );

    modport eng (
        input  cmd_valid, cmd, tx_byte, scl_in, sda_in,
        output ready, done, nack, scl_low, sda_low
    );
endinterface

`default_nettype wire

// ===== design/twm_bit_engine.sv
`timescale 1ns/1ps
`default_nettype none

module twm_bit_engine #(
    parameter int HALF_CYC = twm_pkg::HALF_CYC
) (
    input  wire logic  clk_i,
    input  wire logic  sys_rst_i,
    input  wire logic  ce_i,
    twm_bit_if.eng     bus
);

    typedef enum logic [3:0] {
        E_IDLE, E_ST_WAIT, E_ST_SDA, E_ST_SCL, E_HOLD,
        E_BIT_LO, E_BIT_HI, E_ACK_LO, E_ACK_HI,
        E_SP_LO, E_SP_SCL, E_SP_SDA
    } twm_eng_state_t;

    typedef struct packed {
        twm_eng_state_t state;
        logic [15:0]    cnt;
        logic [2:0]     bitn;
        logic [7:0]     shreg;
        logic           scl_low;
        logic           sda_low;
        logic           done;
        logic           nack;
    } twm_eng_t;

    twm_eng_t q;
    twm_eng_t d;
    logic     tick;

    assign tick        = (q.cnt == 16'(HALF_CYC - 1));
    assign bus.ready   = (q.state == E_IDLE) || (q.state == E_HOLD);
    assign bus.done    = q.done;
    assign bus.nack    = q.nack;
    assign bus.scl_low = q.scl_low;
    assign bus.sda_low = q.sda_low;

    always_comb begin
        d      = q;
        d.done = 1'b0;
        d.cnt  = tick ? q.cnt : q.cnt + 16'h0001;
        unique case (q.state)
            E_IDLE, E_HOLD: begin
                if (bus.cmd_valid) begin
                    d.cnt = '0;
                    unique case (bus.cmd)
                        twm_pkg::CMD_START: d.state = E_ST_WAIT;
                        twm_pkg::CMD_BYTE: begin
                            d.state   = E_BIT_LO;
                            d.scl_low = 1'b1;
                            d.shreg   = bus.tx_byte;
                            d.bitn    = '0;
                        end
                        default: begin
                            d.state   = E_SP_LO;
                            d.scl_low = 1'b1;
                        end
                    endcase
                end
            end
            // Waits for a free bus; also serves a repeated start
            E_ST_WAIT: begin
                d.sda_low = 1'b0;
                if (tick) begin
                    d.scl_low = 1'b0;
                    if (!q.scl_low && bus.scl_in && bus.sda_in) begin
                        d.state = E_ST_SDA;
                        d.cnt   = '0;
                    end
                end
            end
            E_ST_SDA: begin
                d.sda_low = 1'b1;
                if (tick) begin
                    d.state   = E_ST_SCL;
                    d.scl_low = 1'b1;
                    d.cnt     = '0;
                end
            end
            E_ST_SCL: begin
                if (tick) begin
                    d.state = E_HOLD;
                    d.done  = 1'b1;
                end
            end
            E_BIT_LO: begin
                d.sda_low = ~q.shreg[7];
                if (tick) begin
                    d.state   = E_BIT_HI;
                    d.scl_low = 1'b0;
                    d.cnt     = '0;
                end
            end
            // Slave may stretch the clock: wait for the line high
            E_BIT_HI: begin
                if (tick && bus.scl_in) begin
                    d.scl_low = 1'b1;
                    d.cnt     = '0;
                    d.shreg   = {q.shreg[6:0], 1'b0};
                    d.bitn    = q.bitn + 3'h1;
                    d.state   = (q.bitn == 3'h7) ? E_ACK_LO : E_BIT_LO;
                end
            end
            E_ACK_LO: begin
                d.sda_low = 1'b0;
                if (tick) begin
                    d.state   = E_ACK_HI;
                    d.scl_low = 1'b0;
                    d.cnt     = '0;
                end
            end
            E_ACK_HI: begin
                if (tick && bus.scl_in) begin
                    d.nack    = bus.sda_in;
                    d.scl_low = 1'b1;
                    d.state   = E_HOLD;
                    d.done    = 1'b1;
                end
            end
            E_SP_LO: begin
                d.sda_low = 1'b1;
                if (tick) begin
                    d.state   = E_SP_SCL;
                    d.scl_low = 1'b0;
                    d.cnt     = '0;
                end
            end
            E_SP_SCL: begin
                if (tick && bus.scl_in) begin
                    d.state   = E_SP_SDA;
                    d.sda_low = 1'b0;
                    d.cnt     = '0;
                end
            end
            E_SP_SDA: begin
                if (tick) begin
                    d.state = E_IDLE;
                end
            end
            default: d.state = E_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            q <= '0;
        end else if (ce_i) begin
            q <= d;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    a_stop_silent: assert property (q.state == E_SP_SDA && tick && ce_i |=> !q.done && q.state == E_IDLE)
        else $error("stop condition raised completion");
    a_byte_done: assert property (q.state == E_ACK_HI && tick && bus.scl_in && ce_i |=> q.done && q.scl_low)
        else $error("byte end did not signal done with clock held");
    a_start_done: assert property (q.state == E_ST_SCL && tick && ce_i |=> q.done && q.sda_low && q.scl_low)
        else $error("start end did not signal done");

endmodule // twm_bit_engine

`default_nettype wire

// ===== design/twm_two_wire_iface.sv
`timescale 1ns/1ps
`default_nettype none

module twm_two_wire_iface (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        ce_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        cpu_flags_reg_gie_i,
    output logic             irq_o,
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe_n_o,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_n_o
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic              local_irq_enable;
        logic              en;
        logic              sta;
        logic              sto;
        logic              flag;
        logic [7:0]        shift_data_reg;
        logic [7:0]        link_status_reg;
        logic [7:0]        code;
        logic              pend;
        logic              cmd_valid;
        twm_pkg::twm_cmd_t cmd;
        logic              is_addr;
        logic              scl_s1;
        logic              scl_s2;
        logic              sda_s1;
        logic              sda_s2;
        logic              scl_oe_n;
        logic              sda_oe_n;
        logic              line_lvl;
        logic [31:0]       prdata;
        logic              pready;
        logic              pslverr;
        logic              irq;
    } twm_top_t;

    twm_top_t  q;
    twm_top_t  d;
    twm_bit_if bus ();

    logic setup;
    logic wr;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic reg_mapped(input logic [7:0] a);
        return (a == twm_pkg::ADDR_CTRL) || (a == twm_pkg::ADDR_STATUS) || (a == twm_pkg::ADDR_DATA);
    endfunction

    // Event code from the finished operation
    function automatic logic [7:0] event_code(input twm_pkg::twm_cmd_t c,
                                              input logic is_addr,
                                              input logic nack);
        if (c == twm_pkg::CMD_START) begin
            return twm_pkg::ST_START;
        end else if (is_addr) begin
            return nack ? twm_pkg::ST_ADDR_NACK : twm_pkg::ST_ADDR_ACK;
        end
        return nack ? twm_pkg::ST_DATA_NACK : twm_pkg::ST_DATA_ACK;
    endfunction

    // ----------------------------------------------------------------
    // Bit engine
    // ----------------------------------------------------------------
    assign bus.cmd_valid = q.cmd_valid;
    assign bus.cmd       = q.cmd;
    assign bus.tx_byte   = q.shift_data_reg;
    assign bus.scl_in    = q.scl_s2;
    assign bus.sda_in    = q.sda_s2;

    twm_bit_engine #(
        .HALF_CYC (twm_pkg::HALF_CYC)
    ) u_engine (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .ce_i      (ce_i),
        .bus       (bus.eng)
    );

    assign setup = psel_i && !penable_i && !q.pready;
    assign wr    = psel_i && penable_i && q.pready && pwrite_i && !q.pslverr;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        d           = q;
        d.cmd_valid = 1'b0;
        d.pready    = setup;
        d.scl_s1    = scl_i;
        d.scl_s2    = q.scl_s1;
        d.sda_s1    = sda_i;
        d.sda_s2    = q.sda_s1;
        d.scl_oe_n  = !bus.scl_low;
        d.sda_oe_n  = !bus.sda_low;
        d.line_lvl  = 1'b0;

        // Read data is captured in the setup cycle, answer in the first access cycle
        if (setup) begin
            d.pslverr = !reg_mapped(paddr_i);
            unique case (paddr_i)
                twm_pkg::ADDR_CTRL: begin
                    d.prdata                      = '0;
                    d.prdata[twm_pkg::CTL_FLAG]  = q.flag;
                    d.prdata[twm_pkg::CTL_START] = q.sta;
                    d.prdata[twm_pkg::CTL_STOP]  = q.sto;
                    d.prdata[twm_pkg::CTL_EN]    = q.en;
                    d.prdata[twm_pkg::CTL_IE]    = q.local_irq_enable;
                end
                twm_pkg::ADDR_STATUS: d.prdata = {24'h000000, q.link_status_reg};
                twm_pkg::ADDR_DATA:   d.prdata = {24'h000000, q.shift_data_reg};
                default:              d.prdata = '0;
            endcase
        end

        if (wr && paddr_i == twm_pkg::ADDR_DATA) begin
            d.shift_data_reg = pwdata_i[7:0];
        end

        if (wr && paddr_i == twm_pkg::ADDR_CTRL) begin
            d.local_irq_enable = pwdata_i[twm_pkg::CTL_IE];
            d.en               = pwdata_i[twm_pkg::CTL_EN];
            d.sta              = pwdata_i[twm_pkg::CTL_START];
            d.sto              = pwdata_i[twm_pkg::CTL_STOP];
            // A zero in the flag bit does nothing
            if (pwdata_i[twm_pkg::CTL_FLAG]) begin
                d.flag = 1'b0;
                d.pend = pwdata_i[twm_pkg::CTL_EN];
            end
        end

        // Launch only once the flag is down and the engine idles or holds
        if (q.pend && !q.flag && bus.ready && !q.cmd_valid) begin
            d.pend      = 1'b0;
            d.cmd_valid = 1'b1;
            if (q.sta) begin
                d.cmd = twm_pkg::CMD_START;
            end else if (q.sto) begin
                d.cmd = twm_pkg::CMD_STOP;
                d.sto = 1'b0;
            end else begin
                d.cmd = twm_pkg::CMD_BYTE;
            end
        end

        // Set beats a clear arriving in the same cycle
        if (bus.done) begin
            d.flag    = 1'b1;
            d.code    = event_code(q.cmd, q.is_addr, bus.nack);
            d.is_addr = (q.cmd == twm_pkg::CMD_START);
        end

        d.link_status_reg = q.flag ? q.code : twm_pkg::ST_NONE;
        d.irq             = q.flag && q.local_irq_enable && cpu_flags_reg_gie_i;
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            q                 <= '0;
            q.link_status_reg <= twm_pkg::ST_NONE;
            q.scl_oe_n        <= 1'b1;
            q.sda_oe_n        <= 1'b1;
        end else if (ce_i) begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign prdata_o   = q.prdata;
    assign pready_o   = q.pready;
    assign pslverr_o  = q.pslverr;
    assign irq_o      = q.irq;
    assign scl_o      = q.line_lvl;
    assign sda_o      = q.line_lvl;
    assign scl_oe_n_o = q.scl_oe_n;
    assign sda_oe_n_o = q.sda_oe_n;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    a_flag_holds_scl: assert property (q.flag |-> !q.scl_oe_n)
        else $error("clock line released while flag set");
    a_irq_gate_on: assert property (ce_i && q.flag && q.local_irq_enable && cpu_flags_reg_gie_i |=> irq_o)
        else $error("interrupt missing with both enables");
    a_irq_gate_off: assert property (ce_i && !(q.local_irq_enable && cpu_flags_reg_gie_i) |=> !irq_o)
        else $error("interrupt raised without both enables");
    a_status_follows: assert property (ce_i && $rose(q.flag) |-> q.link_status_reg == twm_pkg::ST_NONE ##1 q.link_status_reg == q.code)
        else $error("status not updated cycle after flag");
    a_status_idle: assert property (ce_i && !q.flag |=> q.link_status_reg == twm_pkg::ST_NONE)
        else $error("status not idle code without flag");
    a_start_code: assert property ($rose(q.flag) && q.cmd == twm_pkg::CMD_START |-> q.code == twm_pkg::ST_START)
        else $error("start status code wrong");
    a_no_launch_flag: assert property (q.cmd_valid |-> !q.flag && !$past(q.flag))
        else $error("operation launched while flag set");
    a_flag_clear: assert property (ce_i && wr && paddr_i == twm_pkg::ADDR_CTRL && pwdata_i[twm_pkg::CTL_FLAG] && !bus.done
                                   |=> !q.flag)
        else $error("written one did not clear flag");
    a_zero_keeps: assert property (ce_i && q.flag && wr && paddr_i == twm_pkg::ADDR_CTRL && !pwdata_i[twm_pkg::CTL_FLAG]
                                   |=> q.flag)
        else $error("written zero cleared flag");
    a_launch_prompt: assert property (ce_i && q.pend && !q.flag && bus.ready && !q.cmd_valid |=> q.cmd_valid)
        else $error("pending operation not launched");
    a_stop_no_flag: assert property (ce_i && q.cmd_valid && q.cmd == twm_pkg::CMD_STOP |=> !q.flag [*4])
        else $error("flag raised after stop");

endmodule // twm_two_wire_iface

`default_nettype wire

// ===== test/twm_slave_model.sv
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------
// Receiving slave, may stretch SCL
// ---------------------------------
module twm_slave_model (
    input  wire logic       clk_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    input  wire logic       nack_i,
    input  wire logic [7:0] stretch_i,
    output logic            scl_low_o,
    output logic            sda_low_o,
    output logic [7:0]      byte_o,
    output logic            byte_valid_o,
    output logic            stop_o
);
    logic       scl_q;
    logic       sda_q;
    logic [3:0] bits;
    logic [7:0] sr;
    logic [7:0] hold;

    initial begin
        {scl_q, sda_q, scl_low_o, sda_low_o, byte_valid_o, stop_o, bits, hold} = 18'h30000;
        sr     = 8'h00;
        byte_o = 8'h00;
    end

    always @(posedge clk_i) begin
        byte_valid_o <= 1'b0;
        stop_o       <= 1'b0;
        scl_q        <= scl_i;
        sda_q        <= sda_i;
        if (hold != 8'h00) hold <= hold - 8'h01;
        else scl_low_o <= 1'b0;
        if (scl_i && scl_q && sda_q && !sda_i) bits <= 4'h0;
        if (scl_i && scl_q && !sda_q && sda_i) stop_o <= 1'b1;
        if (scl_i && !scl_q) begin
            if (bits < 4'h8) sr <= {sr[6:0], sda_i};
            bits <= bits + 4'h1;
        end
        // Hold SCL for stretch_i cycles after each fall while stretch_i is nonzero; this ends inside the master's HALF_CYC low half, so the master never waits
        if (!scl_i && scl_q) begin
            hold      <= stretch_i;
            scl_low_o <= (stretch_i != 8'h00);
            if (bits == 4'h8) begin
                sda_low_o    <= !nack_i;
                byte_o       <= sr;
                byte_valid_o <= 1'b1;
            end
            if (bits == 4'h9) begin
                sda_low_o <= 1'b0;
                bits      <= 4'h0;
            end
        end
    end
endmodule // twm_slave_model

`default_nettype wire

// ===== test/twm_two_wire_iface_test.sv
`timescale 1ns/1ps
`default_nettype none

module twm_two_wire_iface_test;
    localparam logic [31:0] FL  = 32'h1 << twm_pkg::CTL_FLAG;
    localparam logic [31:0] STA = 32'h1 << twm_pkg::CTL_START;
    localparam logic [31:0] SP  = 32'h1 << twm_pkg::CTL_STOP;
    localparam logic [31:0] EN  = 32'h1 << twm_pkg::CTL_EN;
    localparam logic [31:0] IE  = 32'h1 << twm_pkg::CTL_IE;

    logic        clk_i = 1'b0, sys_rst_i = 1'b1, ce_i = 1'b1, gie = 1'b0;
    logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [7:0]  paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, prdata_o;
    logic        pready_o, pslverr_o, irq_o, scl_o, scl_oe_n_o, sda_o, sda_oe_n_o;
    logic        nack = 1'b0, s_scl_low, s_sda_low, s_valid, s_stop;
    logic [7:0]  stretch = 8'h00, s_byte;
    logic [33:0] rq[$];
    logic [7:0]  bq[$];
    int          fails = 0, checked = 0, stops = 0, seed = 14432;
    // Open-drain lines with pull-ups
    wire         scl_w = (scl_oe_n_o | scl_o) & ~s_scl_low;
    wire         sda_w = (sda_oe_n_o | sda_o) & ~s_sda_low;

    always #2 clk_i = ~clk_i;

    twm_two_wire_iface u_twm_two_wire_iface (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .cpu_flags_reg_gie_i(gie), .irq_o(irq_o),
        .scl_i(scl_w), .scl_o(scl_o), .scl_oe_n_o(scl_oe_n_o),
        .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o)
    );

    twm_slave_model u_twm_slave_model (
        .clk_i(clk_i), .scl_i(scl_w), .sda_i(sda_w), .nack_i(nack), .stretch_i(stretch),
        .scl_low_o(s_scl_low), .sda_low_o(s_sda_low), .byte_o(s_byte),
        .byte_valid_o(s_valid), .stop_o(s_stop)
    );

    // ---------------------------------
    // Checking and closing
    // ---------------------------------
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic test_done;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    always @(posedge clk_i) begin
        logic [33:0] q;
        if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i) begin
            q = rq.pop_front();
            if (q[33]) chk({pslverr_o, prdata_o}, q[32:0]);
        end
        if (s_stop) stops++;
        if (s_valid) chk(s_byte, (bq.size() != 0) ? bq.pop_front() : 9'h100);
    end

    // ---------------------------------
    // APB master and sequences
    // ---------------------------------
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= w;
        paddr_i   <= a;
        pwdata_i  <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 50);
        r = prdata_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        if (n >= 50) begin
            fails++;
            test_done();
        end
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic c, output logic [31:0] r);
        rq.push_back({c, e});
        apb(1'b0, a, 32'h0, r);
    endtask

    // Polls the flag with the interrupt path unused
    task automatic op(input logic [31:0] c, input logic [7:0] code);
        logic [31:0] r;
        int n;
        apb(1'b1, twm_pkg::ADDR_CTRL, c, r);
        r = 32'h0;
        for (n = 0; r[twm_pkg::CTL_FLAG] !== 1'b1; n++) begin
            rd(twm_pkg::ADDR_CTRL, 33'h0, 1'b0, r);
            if (n > 5000) begin
                fails++;
                test_done();
            end
        end
        repeat (40) @(posedge clk_i);
        chk(scl_oe_n_o, 1'b0);
        rd(twm_pkg::ADDR_STATUS, {25'h0, code}, 1'b1, r);
    endtask

    task automatic send(input logic [7:0] v, input logic [7:0] code);
        logic [31:0] r;
        apb(1'b1, twm_pkg::ADDR_DATA, {24'h0, v}, r);
        bq.push_back(v);
        op(FL | EN, code);
    endtask

    initial begin
        logic [31:0] r;
        logic [7:0]  b;
        int          t;
        int          i;
        repeat (12) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        rd(twm_pkg::ADDR_STATUS, 33'hF8, 1'b1, r);
        rd(twm_pkg::ADDR_CTRL, 33'h0, 1'b1, r);
        rd(twm_pkg::ADDR_DATA, 33'h0, 1'b1, r);
        rd(8'h0C, 33'h100000000, 1'b1, r);
        for (t = 0; t < 2; t++) begin
            op(FL | STA | EN, twm_pkg::ST_START);
            if (t == 0) begin
                apb(1'b1, twm_pkg::ADDR_CTRL, EN | IE, r);
                rd(twm_pkg::ADDR_CTRL, {1'b0, FL | EN | IE}, 1'b1, r);
                gie <= 1'b1;
                repeat (3) @(posedge clk_i);
                chk(irq_o, 1'b1);
                gie <= 1'b0;
                repeat (3) @(posedge clk_i);
                chk(irq_o, 1'b0);
            end
            nack <= t[0];
            b = 8'($random(seed)) & 8'hFE;
            send(b, t ? twm_pkg::ST_ADDR_NACK : twm_pkg::ST_ADDR_ACK);
            for (i = 0; i < 2 && t == 0; i++) begin
                nack    <= i[0];
                stretch <= i[0] ? 8'h28 : 8'h00;
                send(8'($random(seed)), i ? twm_pkg::ST_DATA_NACK : twm_pkg::ST_DATA_ACK);
            end
            apb(1'b1, twm_pkg::ADDR_CTRL, FL | SP | EN, r);
            repeat (3000) @(posedge clk_i);
            rd(twm_pkg::ADDR_CTRL, {1'b0, EN}, 1'b1, r);
            chk(33'(stops), 33'(t + 1));
            chk(scl_w & sda_w, 1'b1);
            chk({scl_o, sda_o}, 2'b00);
        end
        test_done();
    end
endmodule // twm_two_wire_iface_test

`default_nettype wire
